// file: design/sws_pkg.sv
// Package: states, sleep type codes and timing constants for the sleep/wake sequencer
package sws_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OVERRIDE_SEC = 4;
  localparam longint unsigned OVERRIDE_CYC_L = longint'(CLK_HZ) * OVERRIDE_SEC;
  localparam int unsigned OVERRIDE_CYC = 32'(OVERRIDE_CYC_L);
  localparam int unsigned GRACE_NS = 1000;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned GRACE_CYC = (GRACE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] SLP_S0 = 3'h0;
  localparam logic [2:0] SLEEP_OUT_FIRST_N = 3'h1;
  localparam logic [2:0] SLEEP_OUT_SECOND_N = 3'h5;
  localparam logic [2:0] SLP_S4 = 3'h6;
  localparam logic [2:0] SLEEP_OUT_THIRD_N = 3'h7;
  localparam logic [7:0] GTIMER_OFF = 8'h00;
  localparam logic [2:0] SMB_CMD_HARD_NOCYC = 3'h3;
  localparam logic [2:0] SMB_CMD_HARD_SYS = 3'h4;
  localparam int unsigned NUM_GPI = 24;
  localparam logic [NUM_GPI-1:0] RESUME_GPI_MASK = 24'h00FF00;
  typedef enum logic [2:0] {ST_S0, ST_GRACE, ST_S1, ST_S3, ST_S4, ST_S5} sws_state_e;
endpackage

// file: design/sws_sync_if.sv
// Interface: carries raw pins into the synchroniser and clean levels out
`timescale 1ns/100ps
interface sws_sync_if;
  logic [31:0] raw;
  logic [31:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// file: design/sws_sync.sv
// Three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/100ps
module sws_sync
  import sws_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Pins
  sws_sync_if.sync pins
);
  logic [31:0] s1_r, s2_r, s3_r, clean_r;
  logic [31:0] clean_nxt;
  always_comb
  begin
    clean_nxt = clean_r;
    for (int i = 0; i < 32; i++)
      if (s2_r[i] == s3_r[i])
        clean_nxt[i] = s3_r[i];
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s1_r <= 32'hFFFFFFFF;
      s2_r <= 32'hFFFFFFFF;
      s3_r <= 32'hFFFFFFFF;
      clean_r <= 32'hFFFFFFFF;
    end
    else
    begin
      s1_r <= pins.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= clean_nxt;
    end
  end
  assign pins.clean = clean_r;
endmodule

// file: design/sws_top.sv
// Sleep-state sequencer: entry, sleep rails, wake collection and power-failure policy
//
// Functional notes
// - Software masks, clears masters, writes type, sets request; device passes through C-state.
// - Button held over 4 s raises override and forces S5 without processor handshake.
// - S1 asserts only the first sleep output, gating the clock generator.
// - S3 asserts first and second outputs; S4 and S5 assert all three.
// - In S1 the two deeper-sleep outputs may be asserted.
// - Enabled wake returns to S0 and sets wake status.
// - Battery low blocks waking; events are latched and wake once it clears.
// - Power button always wakes from S1 to S5, no enable needed.
// - RTC, resume inputs, ring, codec, PMEs, LAN wake S1-S5 when enabled.
// - USB and SMBus alert wake only from S1 to S4.
// - Standby timer wakes from S1 when its range field is nonzero.
// - SMBus slave wake command always wakes S1-S5, including override S5.
// - Host-notify wakes only if enabled, and sets SMBus wake status.
// - RTC, inputs, ring, secondary PME wake S5 only if software entered it.
// - Override S5 accepts only button, SMBus wake command and SMBus hard-reset commands 3 and 4.
// - Inputs 7:0 and 23:16 wake only from S1; 15:8 from S1-S5.
// - Button status held clear while resume-well reset is low.
// - Ring going low during power loss sets ring status and wakes if ring wake is enabled.
// - Alarm enable survives power loss; alarm status cleared by resume reset.
// - Main power-good low sets main fail flag; resume reset low sets resume flag.
// - PME can wake after power loss; enable cleared by RTC reset, status by resume.
// - On return, policy 1 sends S0/S1/S3/S5 to S5, S4 stays; 0 goes S0.
`timescale 1ns/100ps
module sws_top
  import sws_pkg::*;
#(
  parameter int unsigned OVERRIDE_CYCLES = OVERRIDE_CYC
)
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Software control
  input wire logic [2:0] sleep_type_field_in,
  input wire logic sleep_request_bit_in,
  input wire logic cstate_done_in,
  input wire logic wake_status_clr_in,
  input wire logic smbus_wake_status_clr_in,
  input wire logic alarm_wake_status_clr_in,
  input wire logic ring_wake_status_clr_in,
  input wire logic button_press_status_clr_in,
  input wire logic fail_flags_clr_in,
  input wire logic power_return_policy_bit_in,
  // Wake enables
  input wire logic alarm_wake_enable_in,
  input wire logic [NUM_GPI-1:0] input_event_enable_reg_in,
  input wire logic [2:0] usb_wake_enable_in,
  input wire logic ring_wake_enable_in,
  input wire logic codec_link_wake_enable_in,
  input wire logic primary_pme_wake_enable_in,
  input wire logic secondary_pme_wake_enable_in,
  input wire logic lan_wake_enable_in,
  input wire logic smbus_alert_wake_enable_in,
  input wire logic notify_message_wake_enable_in,
  input wire logic [7:0] global_standby_timer_range_in,
  // Wake sources (same clock domain pulses/levels)
  input wire logic alarm_event_in,
  input wire logic [NUM_GPI-1:0] general_input_event_in,
  input wire logic [2:0] usb_wake_event_in,
  input wire logic codec_link_event_in,
  input wire logic primary_pme_event_in,
  input wire logic lan_event_in,
  input wire logic standby_timeout_in,
  input wire logic smbus_cmd_valid_in,
  input wire logic [2:0] smbus_cmd_type_in,
  input wire logic smbus_wake_cmd_in,
  input wire logic notify_message_in,
  // Pins from outside the domain
  input wire logic power_button_n_in,
  input wire logic battery_low_n_in,
  input wire logic ring_indicate_n_in,
  input wire logic secondary_pme_n_in,
  input wire logic smbus_alert_n_in,
  input wire logic main_power_good_in,
  input wire logic resume_well_reset_n_in,
  input wire logic rtc_well_reset_n_in,
  // Outputs
  output logic sleep_out_first_n_out,
  output logic sleep_out_second_n_out,
  output logic sleep_out_third_n_out,
  output logic deeper_sleep_regulator_out,
  output logic deeper_sleep_cpu_n_out,
  output logic cstate_request_out,
  output logic override_event_out,
  output logic wake_status_bit_out,
  output logic smbus_wake_status_out,
  output logic alarm_wake_status_out,
  output logic ring_wake_status_out,
  output logic secondary_pme_status_out,
  output logic button_press_status_out,
  output logic main_power_fail_flag_out,
  output logic resume_power_fail_flag_out,
  output logic [2:0] state_out
);

  // ==========================================================
  // Pin synchronisation
  sws_sync_if pins ();
  sws_sync u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pins(pins)
  );
  assign pins.raw = {24'hFFFFFF, power_button_n_in, battery_low_n_in, ring_indicate_n_in,
                     secondary_pme_n_in, smbus_alert_n_in, main_power_good_in,
                     resume_well_reset_n_in, rtc_well_reset_n_in};
  logic btn_n, battery_low_n_n, ring_n, spme_n, salert_n, pgood, rsm_n, rtc_n;
  assign {btn_n, battery_low_n_n, ring_n, spme_n, salert_n, pgood, rsm_n, rtc_n} = pins.clean[7:0];

  // ==========================================================
  // State machine and status
  sws_state_e state_r, state_nxt;
  logic sw_entry_r, sw_entry_nxt;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic [7:0] grace_cnt_r, grace_cnt_nxt;
  logic wake_pend_r, wake_pend_nxt;
  logic lost_r, lost_nxt;
  logic [2:0] lost_state_r, lost_state_nxt;
  logic pgood_d_r, rsm_d_r, ring_d_r, btn_d_r;
  logic wak_r, wak_nxt, smbs_r, smbs_nxt, alrm_r, alrm_nxt, ring_r, ring_nxt;
  logic spme_r, spme_nxt, btns_r, btns_nxt, mfail_r, mfail_nxt, rfail_r, rfail_nxt;
  logic ovr_r, ovr_nxt, spme_en_ok_r, spme_en_ok_nxt;
  logic ring_lost_r, ring_lost_nxt;
  logic in_sleep, s5_any, s5_sw, s5_ovr, wake_now, btn_press;
  logic [NUM_GPI-1:0] gpi_hit;

  assign in_sleep = (state_r == ST_S1) || (state_r == ST_S3) || (state_r == ST_S4) || (state_r == ST_S5);
  assign s5_any = (state_r == ST_S5);
  assign s5_sw = s5_any && sw_entry_r;
  assign s5_ovr = s5_any && !sw_entry_r;
  assign btn_press = btn_d_r && !btn_n;

  always_comb
  begin
    gpi_hit = general_input_event_in & input_event_enable_reg_in;
    if (state_r != ST_S1)
      gpi_hit = gpi_hit & RESUME_GPI_MASK;
    if (s5_any && !sw_entry_r)
      gpi_hit = '0;
  end

  always_comb
  begin
    wake_now = 1'b0;
    if (in_sleep)
    begin
      wake_now = btn_press;
      wake_now = wake_now || smbus_wake_cmd_in;
      wake_now = wake_now || (smbus_cmd_valid_in && ((smbus_cmd_type_in == SMB_CMD_HARD_NOCYC)
                 || (smbus_cmd_type_in == SMB_CMD_HARD_SYS)));
      if (!s5_ovr)
      begin
        wake_now = wake_now || (|gpi_hit) || (codec_link_event_in && codec_link_wake_enable_in)
                   || (primary_pme_event_in && primary_pme_wake_enable_in)
                   || (lan_event_in && lan_wake_enable_in)
                   || (notify_message_in && notify_message_wake_enable_in);
        if (!s5_any || s5_sw)
          wake_now = wake_now || (alrm_r && alarm_wake_enable_in) || (ring_r && ring_wake_enable_in)
                     || (spme_r && secondary_pme_wake_enable_in && spme_en_ok_r);
        if (!s5_any)
          wake_now = wake_now || (|(usb_wake_event_in & usb_wake_enable_in))
                     || (!salert_n && smbus_alert_wake_enable_in);
        if (state_r == ST_S1)
          wake_now = wake_now || (standby_timeout_in && (global_standby_timer_range_in != GTIMER_OFF));
      end
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    sw_entry_nxt = sw_entry_r;
    hold_cnt_nxt = btn_n ? 32'h0 : hold_cnt_r + 32'h1;
    grace_cnt_nxt = grace_cnt_r;
    wake_pend_nxt = wake_pend_r || wake_now;
    ovr_nxt = 1'b0;
    lost_nxt = lost_r;
    lost_state_nxt = lost_state_r;
    wak_nxt = wak_r && !wake_status_clr_in;
    smbs_nxt = (smbs_r && !smbus_wake_status_clr_in)
               || (in_sleep && notify_message_in && notify_message_wake_enable_in);
    alrm_nxt = (alrm_r && !alarm_wake_status_clr_in) || alarm_event_in;
    ring_nxt = (ring_r && !ring_wake_status_clr_in) || (ring_d_r && !ring_n);
    // Secondary PME status shares the ring status clear strobe
    spme_nxt = (spme_r && !ring_wake_status_clr_in) || !spme_n;
    btns_nxt = (btns_r && !button_press_status_clr_in) || btn_press;
    mfail_nxt = (mfail_r && !fail_flags_clr_in) || (pgood_d_r && !pgood);
    rfail_nxt = (rfail_r && !fail_flags_clr_in) || (rsm_d_r && !rsm_n);
    spme_en_ok_nxt = spme_en_ok_r;
    ring_lost_nxt = ring_lost_r;
    if (!rtc_n)
      spme_en_ok_nxt = 1'b0;
    else if (secondary_pme_wake_enable_in && !lost_r)
      spme_en_ok_nxt = 1'b1;
    if (!pgood || !rsm_n)
    begin
      if (!lost_r)
        lost_state_nxt = (state_r == ST_S4) ? SLP_S4 : (state_r == ST_S5) ? SLEEP_OUT_THIRD_N : SLP_S0;
      lost_nxt = 1'b1;
      if (!ring_n)
        ring_lost_nxt = 1'b1;
    end
    if (!rsm_n)
    begin
      btns_nxt = 1'b0;
      alrm_nxt = 1'b0;
      spme_nxt = 1'b0;
      wake_pend_nxt = 1'b0;
    end
    unique case (state_r)
      ST_S0:
      begin
        if (sleep_request_bit_in && (sleep_type_field_in != SLP_S0))
        begin
          state_nxt = ST_GRACE;
          grace_cnt_nxt = 8'(GRACE_CYC);
        end
      end
      ST_GRACE:
      begin
        if (cstate_done_in || (grace_cnt_r == 8'h00))
        begin
          sw_entry_nxt = 1'b1;
          unique case (sleep_type_field_in)
            SLEEP_OUT_FIRST_N: state_nxt = ST_S1;
            SLEEP_OUT_SECOND_N: state_nxt = ST_S3;
            SLP_S4: state_nxt = ST_S4;
            default: state_nxt = ST_S5;
          endcase
        end
        else
          grace_cnt_nxt = grace_cnt_r - 8'h01;
      end
      ST_S1, ST_S3, ST_S4, ST_S5:
      begin
        if ((wake_pend_r || wake_now) && battery_low_n_n)
        begin
          state_nxt = ST_S0;
          wak_nxt = 1'b1;
          wake_pend_nxt = 1'b0;
        end
      end
    endcase
    if (state_r != ST_S5 && hold_cnt_r == OVERRIDE_CYCLES)
    begin
      state_nxt = ST_S5;
      sw_entry_nxt = 1'b0;
      ovr_nxt = 1'b1;
      wake_pend_nxt = 1'b0;
    end
    if (lost_r && pgood && rsm_n)
    begin
      lost_nxt = 1'b0;
      wake_pend_nxt = 1'b0;
      sw_entry_nxt = 1'b0;
      if (!power_return_policy_bit_in)
        state_nxt = ST_S0;
      else
        state_nxt = (lost_state_r == SLP_S4) ? ST_S4 : ST_S5;
      if (ring_lost_r)
      begin
        ring_nxt = 1'b1;
        ring_lost_nxt = 1'b0;
        if (power_return_policy_bit_in && ring_wake_enable_in)
          wake_pend_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_S0;
      sw_entry_r <= 1'b0;
      hold_cnt_r <= 32'h0;
      grace_cnt_r <= 8'h00;
      wake_pend_r <= 1'b0;
      lost_r <= 1'b0;
      lost_state_r <= SLP_S0;
      pgood_d_r <= 1'b1;
      rsm_d_r <= 1'b1;
      ring_d_r <= 1'b1;
      btn_d_r <= 1'b1;
      {wak_r, smbs_r, alrm_r, ring_r, spme_r, btns_r, mfail_r, rfail_r} <= 8'h00;
      ovr_r <= 1'b0;
      spme_en_ok_r <= 1'b0;
      ring_lost_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sw_entry_r <= sw_entry_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      grace_cnt_r <= grace_cnt_nxt;
      wake_pend_r <= wake_pend_nxt;
      lost_r <= lost_nxt;
      lost_state_r <= lost_state_nxt;
      pgood_d_r <= pgood;
      rsm_d_r <= rsm_n;
      ring_d_r <= ring_n;
      btn_d_r <= btn_n;
      {wak_r, smbs_r, alrm_r, ring_r, spme_r, btns_r, mfail_r, rfail_r} <=
        {wak_nxt, smbs_nxt, alrm_nxt, ring_nxt, spme_nxt, btns_nxt, mfail_nxt, rfail_nxt};
      ovr_r <= ovr_nxt;
      spme_en_ok_r <= spme_en_ok_nxt;
      ring_lost_r <= ring_lost_nxt;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sleep_out_first_n_out <= 1'b1;
      sleep_out_second_n_out <= 1'b1;
      sleep_out_third_n_out <= 1'b1;
      deeper_sleep_regulator_out <= 1'b0;
      deeper_sleep_cpu_n_out <= 1'b1;
      cstate_request_out <= 1'b0;
      state_out <= SLP_S0;
    end
    else
    begin
      sleep_out_first_n_out <= !(state_nxt inside {ST_S1, ST_S3, ST_S4, ST_S5});
      sleep_out_second_n_out <= !(state_nxt inside {ST_S3, ST_S4, ST_S5});
      sleep_out_third_n_out <= !(state_nxt inside {ST_S4, ST_S5});
      deeper_sleep_regulator_out <= (state_nxt == ST_S1);
      deeper_sleep_cpu_n_out <= !(state_nxt == ST_S1);
      cstate_request_out <= (state_nxt == ST_GRACE);
      state_out <= (state_nxt == ST_S1) ? SLEEP_OUT_FIRST_N : (state_nxt == ST_S3) ? SLEEP_OUT_SECOND_N :
                   (state_nxt == ST_S4) ? SLP_S4 : (state_nxt == ST_S5) ? SLEEP_OUT_THIRD_N : SLP_S0;
    end
  end
  assign override_event_out = ovr_r;
  assign wake_status_bit_out = wak_r;
  assign smbus_wake_status_out = smbs_r;
  assign alarm_wake_status_out = alrm_r;
  assign ring_wake_status_out = ring_r;
  assign secondary_pme_status_out = spme_r;
  assign button_press_status_out = btns_r;
  assign main_power_fail_flag_out = mfail_r;
  assign resume_power_fail_flag_out = rfail_r;

  // ==========================================================
  // Assertions
  s1_rails_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_S1 |-> !sleep_out_first_n_out && sleep_out_second_n_out && sleep_out_third_n_out)
    else $error("S1 rails wrong");
  s3_rails_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == ST_S3 |-> !sleep_out_second_n_out && sleep_out_third_n_out)
    else $error("S3 rails wrong");
  s45_rails_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_r == ST_S4 || state_r == ST_S5) |-> !sleep_out_third_n_out && !sleep_out_first_n_out)
    else $error("S4/S5 rails wrong");
  wake_status_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_sleep && state_nxt == ST_S0 && !lost_r |=> wak_r)
    else $error("wake status not set");
  battery_low_n_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_sleep && !battery_low_n_n && !lost_r && hold_cnt_r != OVERRIDE_CYCLES |=> state_r == $past(state_r))
    else $error("woke under battery low");
  usb_s5_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    s5_any && !btn_press && !smbus_wake_cmd_in && !smbus_cmd_valid_in && !notify_message_in
    && !(|gpi_hit) && !codec_link_event_in && !primary_pme_event_in && !lan_event_in
    && !alrm_r && !ring_r && !spme_r |-> !wake_now)
    else $error("S5 wake from S1-S4 source");
  btn_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rsm_n |=> !btns_r)
    else $error("button status not cleared");
  mfail_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    pgood_d_r && !pgood |=> mfail_r)
    else $error("main fail flag not set");
  override_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovr_r |-> state_r == ST_S5 && !sw_entry_r)
    else $error("override did not reach S5");
  policy_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    lost_r && pgood && rsm_n && !power_return_policy_bit_in |=> state_r == ST_S0)
    else $error("power return policy ignored");
endmodule

// file: tb/sws_rail_model.sv
// Far-side model: power rails, clock generator and processor taken from the sleep controls
`timescale 1ns/100ps
module sws_rail_model
(
  // Sleep controls from the sequencer
  input wire logic sleep_out_first_n_in,
  input wire logic sleep_out_second_n_in,
  input wire logic sleep_out_third_n_in,
  input wire logic deeper_sleep_cpu_n_in,
  // Rail and clock state seen by the system
  output logic clkgen_on_out,
  output logic core_rail_on_out,
  output logic mem_rail_on_out,
  output logic cpu_deep_out
);
  // ==========================================================
  // Rails
  // A rail is on only while its control sits at the idle high level
  assign clkgen_on_out = sleep_out_first_n_in;
  assign core_rail_on_out = sleep_out_second_n_in;
  assign mem_rail_on_out = sleep_out_third_n_in;
  assign cpu_deep_out = !deeper_sleep_cpu_n_in;
endmodule

// file: tb/sws_top_tb.sv
// Self-checking bench for the sleep/wake sequencer
`timescale 1ns/100ps
module sws_top_tb
  import sws_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int unsigned OVR = 20;
  logic mclk_in, rst_in, sleep_request_bit_in, cstate_done_in, wake_status_clr_in;
  logic smbus_wake_status_clr_in, alarm_wake_status_clr_in, ring_wake_status_clr_in;
  logic button_press_status_clr_in, fail_flags_clr_in, power_return_policy_bit_in;
  logic alarm_wake_enable_in, ring_wake_enable_in, codec_link_wake_enable_in;
  logic primary_pme_wake_enable_in, secondary_pme_wake_enable_in, lan_wake_enable_in;
  logic smbus_alert_wake_enable_in, notify_message_wake_enable_in;
  logic [2:0] sleep_type_field_in, usb_wake_enable_in, usb_wake_event_in, smbus_cmd_type_in;
  logic [NUM_GPI-1:0] input_event_enable_reg_in, general_input_event_in;
  logic [7:0] global_standby_timer_range_in;
  logic alarm_event_in, codec_link_event_in, primary_pme_event_in, lan_event_in;
  logic standby_timeout_in, smbus_cmd_valid_in, smbus_wake_cmd_in, notify_message_in;
  logic power_button_n_in, battery_low_n_in, ring_indicate_n_in, secondary_pme_n_in;
  logic smbus_alert_n_in, main_power_good_in, resume_well_reset_n_in, rtc_well_reset_n_in;
  logic sleep_out_first_n_out, sleep_out_second_n_out, sleep_out_third_n_out;
  logic deeper_sleep_regulator_out, deeper_sleep_cpu_n_out, cstate_request_out, override_event_out;
  logic wake_status_bit_out, smbus_wake_status_out, alarm_wake_status_out, ring_wake_status_out;
  logic secondary_pme_status_out, button_press_status_out, main_power_fail_flag_out;
  logic resume_power_fail_flag_out;
  logic [2:0] state_out;
  logic clkgen_on, core_on, mem_on, cpu_deep;
  int failures = 0;
  int compares = 0;

  sws_top #(.OVERRIDE_CYCLES(OVR)) dut (.*);

  sws_rail_model rails (
    .sleep_out_first_n_in(sleep_out_first_n_out),
    .sleep_out_second_n_in(sleep_out_second_n_out),
    .sleep_out_third_n_in(sleep_out_third_n_out),
    .deeper_sleep_cpu_n_in(deeper_sleep_cpu_n_out),
    .clkgen_on_out(clkgen_on),
    .core_rail_on_out(core_on),
    .mem_rail_on_out(mem_on),
    .cpu_deep_out(cpu_deep)
  );

  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // ==========================================================
  // Reference model and helpers
  // Rail pattern {clock gen, core, memory, deeper sleep} expected per state code
  function automatic logic [3:0] exp_rails(input int st);
    case (st)
      1: return 4'h7;
      5: return 4'h2;
      6, 7: return 4'h0;
      default: return 4'hE;
    endcase
  endfunction

  task automatic finish_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Bounded wait for a state; the design walks in a few cycles, so a long wait means a hang
  task automatic wait_state(input logic [2:0] st);
    int n;
    n = 0;
    while (state_out !== st && n < 200)
    begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      $display("CHECK FAILED state wait expected %0h seen %0h", st, state_out);
      finish_test();
    end
  endtask

  task automatic check_rails(input logic [2:0] st);
    @(negedge mclk_in);
    check("state", 8'(state_out), 8'(st));
    check("rails", 8'({clkgen_on, core_on, mem_on, cpu_deep}), 8'(exp_rails(int'(st))));
    check("regulator", 8'(deeper_sleep_regulator_out), 8'(st == SLEEP_OUT_FIRST_N));
  endtask

  task automatic enter(input logic [2:0] t);
    @(negedge mclk_in);
    sleep_type_field_in = t;
    sleep_request_bit_in = 1'b1;
    @(negedge mclk_in);
    sleep_request_bit_in = 1'b0;
    check("cstate request", 8'(cstate_request_out), 8'h01);
    repeat (3) @(negedge mclk_in);
    cstate_done_in = 1'b1;
    @(negedge mclk_in);
    cstate_done_in = 1'b0;
    wait_state(t);
    check_rails(t);
  endtask

  task automatic press();
    power_button_n_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    power_button_n_in = 1'b1;
    wait_state(SLP_S0);
  endtask

  task automatic stays(input logic [2:0] st);
    repeat (20) @(negedge mclk_in);
    check("no wake", 8'(state_out), 8'(st));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int k;
    logic [2:0] types [4];
    types = '{SLEEP_OUT_FIRST_N, SLEEP_OUT_SECOND_N, SLP_S4, SLEEP_OUT_THIRD_N};
    {rst_in, sleep_request_bit_in, cstate_done_in, wake_status_clr_in, smbus_wake_status_clr_in} = 5'h10;
    {alarm_wake_status_clr_in, ring_wake_status_clr_in, button_press_status_clr_in, fail_flags_clr_in} = 4'h0;
    {power_return_policy_bit_in, ring_wake_enable_in, codec_link_wake_enable_in} = 3'h2;
    {alarm_wake_enable_in, primary_pme_wake_enable_in, secondary_pme_wake_enable_in} = 3'h4;
    {lan_wake_enable_in, smbus_alert_wake_enable_in, notify_message_wake_enable_in} = 3'h5;
    {sleep_type_field_in, usb_wake_enable_in, usb_wake_event_in, smbus_cmd_type_in} = 12'h0;
    {input_event_enable_reg_in, general_input_event_in, global_standby_timer_range_in} = 56'h0;
    {alarm_event_in, codec_link_event_in, primary_pme_event_in, lan_event_in} = 4'h0;
    {standby_timeout_in, smbus_cmd_valid_in, smbus_wake_cmd_in, notify_message_in} = 4'h0;
    {power_button_n_in, battery_low_n_in, ring_indicate_n_in, secondary_pme_n_in} = 4'hF;
    {smbus_alert_n_in, main_power_good_in, resume_well_reset_n_in, rtc_well_reset_n_in} = 4'hF;
    void'($urandom(32'h6506));
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    check_rails(SLP_S0);
    check("wake status", 8'(wake_status_bit_out), 8'h00);
    // Every sleep type, left by an enabled LAN wake
    for (k = 0; k < 4; k++)
    begin
      enter(types[k]);
      lan_event_in = 1'b1;
      @(negedge mclk_in);
      lan_event_in = 1'b0;
      wait_state(SLP_S0);
      check("wake status", 8'(wake_status_bit_out), 8'h01);
      wake_status_clr_in = 1'b1;
      @(negedge mclk_in);
      wake_status_clr_in = 1'b0;
      check_rails(SLP_S0);
    end
    // Standby timeout wakes S1 once its range is nonzero
    global_standby_timer_range_in = 8'h01 + 8'($urandom % 255);
    enter(SLEEP_OUT_FIRST_N);
    standby_timeout_in = 1'b1;
    @(negedge mclk_in);
    standby_timeout_in = 1'b0;
    wait_state(SLP_S0);
    // USB ignored in S5, honoured in S3
    usb_wake_enable_in = 3'h7;
    enter(SLEEP_OUT_THIRD_N);
    usb_wake_event_in = 3'h1 << ($urandom % 3);
    @(negedge mclk_in);
    usb_wake_event_in = 3'h0;
    stays(SLEEP_OUT_THIRD_N);
    press();
    enter(SLEEP_OUT_SECOND_N);
    usb_wake_event_in = 3'h1 << ($urandom % 3);
    @(negedge mclk_in);
    usb_wake_event_in = 3'h0;
    wait_state(SLP_S0);
    // Core-well inputs stay asleep in S3, resume-well inputs wake
    input_event_enable_reg_in = '1;
    enter(SLEEP_OUT_SECOND_N);
    general_input_event_in = 24'h1 << ($urandom % 8);
    @(negedge mclk_in);
    general_input_event_in = '0;
    stays(SLEEP_OUT_SECOND_N);
    general_input_event_in = 24'h100 << ($urandom % 8);
    @(negedge mclk_in);
    general_input_event_in = '0;
    wait_state(SLP_S0);
    // Battery low holds a latched wake back
    enter(SLEEP_OUT_FIRST_N);
    battery_low_n_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    notify_message_in = 1'b1;
    @(negedge mclk_in);
    notify_message_in = 1'b0;
    stays(SLEEP_OUT_FIRST_N);
    battery_low_n_in = 1'b1;
    wait_state(SLP_S0);
    check("smbus wake status", 8'(smbus_wake_status_out), 8'h01);
    // Long press forces S5; only hard-reset commands, the SMBus wake command and the button leave it
    power_button_n_in = 1'b0;
    k = 0;
    while (override_event_out !== 1'b1 && k < 100)
    begin
      @(negedge mclk_in);
      k++;
    end
    check("override", 8'(override_event_out), 8'h01);
    power_button_n_in = 1'b1;
    wait_state(SLEEP_OUT_THIRD_N);
    alarm_event_in = 1'b1;
    @(negedge mclk_in);
    alarm_event_in = 1'b0;
    stays(SLEEP_OUT_THIRD_N);
    smbus_cmd_valid_in = 1'b1;
    smbus_cmd_type_in = ($urandom % 2) ? SMB_CMD_HARD_NOCYC : SMB_CMD_HARD_SYS;
    @(negedge mclk_in);
    smbus_cmd_valid_in = 1'b0;
    wait_state(SLP_S0);
    // Main power loss in S0 with the stay-off policy
    power_return_policy_bit_in = 1'b1;
    main_power_good_in = 1'b0;
    secondary_pme_n_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    check("main fail", 8'(main_power_fail_flag_out), 8'h01);
    check("pme status", 8'(secondary_pme_status_out), 8'h01);
    main_power_good_in = 1'b1;
    secondary_pme_n_in = 1'b1;
    wait_state(SLEEP_OUT_THIRD_N);
    press();
    // Resume-well loss with ring active and the boot policy
    power_return_policy_bit_in = 1'b0;
    ring_wake_enable_in = 1'b1;
    resume_well_reset_n_in = 1'b0;
    ring_indicate_n_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    check("button status", 8'(button_press_status_out), 8'h00);
    check("resume fail", 8'(resume_power_fail_flag_out), 8'h01);
    check("alarm status", 8'(alarm_wake_status_out), 8'h00);
    check("pme status", 8'(secondary_pme_status_out), 8'h00);
    ring_indicate_n_in = 1'b1;
    resume_well_reset_n_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    wait_state(SLP_S0);
    check("ring status", 8'(ring_wake_status_out), 8'h01);
    finish_test();
  end
endmodule
